//--- src/sram_io_cfg.svh
`ifndef SRAM_IO_CFG_SVH
`define SRAM_IO_CFG_SVH

// array geometry
`define SRAM_ADDR_W 6
`define SRAM_DEPTH 64
`define SRAM_LANES 4
`define SRAM_LANE_W 8
`define SRAM_DATA_W 32
`define SRAM_BURST_W 2

// field positions inside a stored lane word and inside the word address
`define SRAM_PAR_BIT 8
`define SRAM_LOW_ADDR_MSB 1
`define SRAM_UP_ADDR_LSB 2

// reset values, and the all-lanes-off byte select pattern
`define SRAM_RST_COUNT 2'h0
`define SRAM_RST_START 2'h0
`define SRAM_RST_UPPER 4'h0
`define SRAM_RST_ADDR 6'h00
`define SRAM_RST_LANE 9'h000
`define SRAM_RST_WE 4'h0
`define SRAM_RST_DATA 32'h0000_0000
`define SRAM_RST_PAR 4'h0
`define SRAM_LANES_OFF 4'hF

`endif

//--- src/sram_io_pkg.sv
`include "sram_io_cfg.svh"

package sram_io_pkg;

  // selection state of the data path
  typedef enum logic [1:0] {
    SEL_IDLE,
    SEL_FIRST,
    SEL_ACTIVE
  } sel_state_t;

  typedef logic [`SRAM_LANE_W:0] lane_word_t;
  typedef logic [`SRAM_ADDR_W-1:0] word_addr_t;
  typedef logic [`SRAM_BURST_W-1:0] burst_t;

endpackage : sram_io_pkg

//--- src/sync_sram_data_io_path.sv
// Overview of operation
// [R1] capture data lanes every rising clock edge
// [R2] read data from the address taken on the same edge
// [R3] output enable low drives, high floats
// [R4] writes force outputs off regardless of enable
// [R5] first cycle after deselect keeps outputs off
// [R6] deselected device never drives the lanes
// [R7] parity lanes follow their byte write select
// [R8] strap low linear, high interleaved burst
// [R9] strap stays fixed during operation
// [R10] test output changes on falling test clock
// [R11] enable masked on first read from deselect
// [R12] chip selects sampled only on address strobe
// [R13] two-bit burst counter, add or xor
`timescale 1ns/1ps
`default_nettype none
`include "sram_io_cfg.svh"

module sync_sram_data_io_path (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [`SRAM_ADDR_W-1:0] addr_in,
  input wire logic adsp_n_in,
  input wire logic adsc_n_in,
  input wire logic adv_n_in,
  input wire logic chip_select_primary_n_in,
  input wire logic chip_select_expand_high_in,
  input wire logic chip_select_expand_low_n_in,
  input wire logic global_write_n_in,
  input wire logic byte_write_enable_n_in,
  input wire logic [`SRAM_LANES-1:0] byte_write_select_n_in,
  input wire logic output_enable_n_in,
  input wire logic burst_order_in,
  input wire logic [`SRAM_DATA_W-1:0] data_lanes_in,
  input wire logic [`SRAM_LANES-1:0] parity_lanes_in,
  input wire logic tck_in,
  input wire logic tdi_in,
  output logic [`SRAM_DATA_W-1:0] data_lanes_out,
  output logic data_lanes_oe_out,
  output logic [`SRAM_LANES-1:0] parity_lanes_out,
  output logic parity_lanes_oe_out,
  output logic tdo_out
);

  sram_io_pkg::sel_state_t state;
  sram_io_pkg::sel_state_t next_state;
  sram_io_pkg::burst_t start;
  sram_io_pkg::burst_t count;
  sram_io_pkg::burst_t next_start;
  sram_io_pkg::burst_t next_count;
  sram_io_pkg::burst_t next_low;
  logic [`SRAM_ADDR_W-3:0] upper;
  logic [`SRAM_ADDR_W-3:0] next_upper;
  sram_io_pkg::word_addr_t next_addr;
  sram_io_pkg::word_addr_t wr_addr;
  sram_io_pkg::word_addr_t pend_addr;
  logic [`SRAM_LANES-1:0] lane_we;
  logic [`SRAM_LANES-1:0] pend_we;
  logic [`SRAM_DATA_W-1:0] din_q;
  logic [`SRAM_LANES-1:0] par_q;
  logic interleave;
  logic strap_taken;
  logic load_p;
  logic load_c;
  logic load;
  logic cs_ok;
  logic wr_req;
  logic write_take;
  logic selected;
  logic adv_step;
  logic next_drive;
  logic tck_prev;
  logic tck_rise;
  logic tck_fall;
  logic tdi_cap;

  // strobe decode; the processor strobe is dead while primary select is high
  assign load_p = !adsp_n_in && !chip_select_primary_n_in;
  assign load_c = !adsc_n_in && !load_p;
  assign load = load_p || load_c;
  // selects only matter on a strobe edge
  assign cs_ok = !chip_select_primary_n_in && chip_select_expand_high_in &&
                 !chip_select_expand_low_n_in; // [R12]
  assign selected = state != sram_io_pkg::SEL_IDLE;

  // write decode: global write overrides the byte selects
  assign wr_req = !global_write_n_in ||
                  (!byte_write_enable_n_in &&
                   (byte_write_select_n_in != `SRAM_LANES_OFF));
  // write inputs are ignored on the processor strobe cycle
  assign write_take = !load_p && wr_req &&
                      (load_c ? cs_ok : selected);

  // burst sequencing
  assign adv_step = !load && !adv_n_in && selected;
  assign next_start = load ? addr_in[`SRAM_LOW_ADDR_MSB:0] : start;
  assign next_count = load ? `SRAM_RST_COUNT :
                      adv_step ? 2'(count + 2'h1) : count; // [R13]
  assign next_upper = load ? addr_in[`SRAM_ADDR_W-1:`SRAM_UP_ADDR_LSB] :
                      upper;
  assign next_low = interleave ? (next_start ^ next_count) :
                    2'(next_start + next_count); // [R8] [R13]
  assign next_addr = {next_upper, next_low};
  // writes land where a read on this edge would look, advance included
  assign wr_addr = next_addr; // [R13]

  // selection tracking
  always_comb begin
    next_state = state;
    if (load) begin
      if (!cs_ok) begin
        next_state = sram_io_pkg::SEL_IDLE; // [R6]
      end else if (state == sram_io_pkg::SEL_IDLE) begin
        next_state = sram_io_pkg::SEL_FIRST; // [R5] [R11]
      end else begin
        next_state = sram_io_pkg::SEL_ACTIVE;
      end
    end else begin
      case (state)
        sram_io_pkg::SEL_IDLE: next_state = sram_io_pkg::SEL_IDLE;
        sram_io_pkg::SEL_FIRST: next_state = sram_io_pkg::SEL_ACTIVE;
        sram_io_pkg::SEL_ACTIVE: next_state = sram_io_pkg::SEL_ACTIVE;
        default: next_state = sram_io_pkg::SEL_IDLE;
      endcase
    end
  end

  // registered enable: one cycle behind the pin, traded for flop outputs
  assign next_drive = !output_enable_n_in && // [R3]
                      (next_state == sram_io_pkg::SEL_ACTIVE) && // [R5] [R6] [R11]
                      !write_take; // [R4]

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= sram_io_pkg::SEL_IDLE;
      start <= `SRAM_RST_START;
      count <= `SRAM_RST_COUNT;
      upper <= `SRAM_RST_UPPER;
    end else begin
      state <= next_state;
      start <= next_start;
      count <= next_count;
      upper <= next_upper;
    end
  end

  // strap caught once after release; it must not move afterwards
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strap_taken <= 1'b0;
      interleave <= 1'b1;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      interleave <= burst_order_in; // [R8] [R9]
    end
  end

  // input data register; writes commit one edge later from it
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      din_q <= `SRAM_RST_DATA;
      par_q <= `SRAM_RST_PAR;
      pend_we <= `SRAM_RST_WE;
      pend_addr <= `SRAM_RST_ADDR;
    end else begin
      din_q <= data_lanes_in; // [R1]
      par_q <= parity_lanes_in; // [R1] [R7]
      pend_we <= write_take ? lane_we : `SRAM_RST_WE;
      pend_addr <= wr_addr;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      data_lanes_oe_out <= 1'b0;
      parity_lanes_oe_out <= 1'b0;
    end else begin
      data_lanes_oe_out <= next_drive; // [R3]
      parity_lanes_oe_out <= next_drive; // [R3] [R7]
    end
  end

  genvar i;
  generate
    for (i = 0; i < `SRAM_LANES; i = i + 1) begin : g_lane
      sram_io_pkg::lane_word_t lane_mem [`SRAM_DEPTH];
      sram_io_pkg::lane_word_t wr_word;
      sram_io_pkg::lane_word_t rd_word;
      logic fwd;
      sram_io_pkg::lane_word_t lane_q;

      assign lane_we[i] = !global_write_n_in ||
                          (!byte_write_enable_n_in &&
                           !byte_write_select_n_in[i]); // [R7]
      assign wr_word = {par_q[i], din_q[i*`SRAM_LANE_W +: `SRAM_LANE_W]};
      // forward a write still in flight so a read never sees stale bytes
      assign fwd = pend_we[i] && (pend_addr == next_addr);
      assign rd_word = fwd ? wr_word : lane_mem[next_addr];

      // array is not reset; contents are undefined until written
      always_ff @(posedge clk_in) begin
        if (pend_we[i]) begin
          lane_mem[pend_addr] <= wr_word; // [R7]
        end
      end

      // flow-through: word at the address taken on this edge
      always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          lane_q <= `SRAM_RST_LANE;
        end else begin
          lane_q <= rd_word; // [R2]
        end
      end

      assign data_lanes_out[i*`SRAM_LANE_W +: `SRAM_LANE_W] =
        lane_q[`SRAM_LANE_W-1:0];
      assign parity_lanes_out[i] = lane_q[`SRAM_PAR_BIT]; // [R7]
    end
  endgenerate

  // test clock is sampled, not used as a clock
  assign tck_rise = tck_in && !tck_prev;
  assign tck_fall = !tck_in && tck_prev;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tck_prev <= 1'b0;
      tdi_cap <= 1'b0;
      tdo_out <= 1'b0;
    end else begin
      tck_prev <= tck_in;
      if (tck_rise) begin
        tdi_cap <= tdi_in;
      end
      if (tck_fall) begin
        tdo_out <= tdi_cap; // [R10]
      end
    end
  end

endmodule : sync_sram_data_io_path
`default_nettype wire

//--- testbench/sram_io_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "sram_io_cfg.svh"
module sram_io_monitor (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic adsp_n_in,
  input wire logic adsc_n_in,
  input wire logic adv_n_in,
  input wire logic chip_select_primary_n_in,
  input wire logic global_write_n_in,
  input wire logic byte_write_enable_n_in,
  input wire logic output_enable_n_in,
  input wire logic tck_in,
  input wire logic [`SRAM_DATA_W-1:0] data_lanes_out,
  input wire logic data_lanes_oe_out,
  input wire logic parity_lanes_oe_out,
  input wire logic tdo_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // adsp is ignored with primary select high, so only adsc can deselect
  wire off = chip_select_primary_n_in & !adsc_n_in;
  wire sel = !adsp_n_in & !chip_select_primary_n_in;
  wire calm = adsp_n_in & adsc_n_in & global_write_n_in
    & byte_write_enable_n_in;
  wire still = calm & adv_n_in;
  wire oe = data_lanes_oe_out;
  par_oe_a: assert property (parity_lanes_oe_out == oe)
    else $error("parity enable differs");
  oe_high_a: assert property (output_enable_n_in |=> !oe)
    else $error("driving with enable off");
  oe_keep_a: assert property (
    oe && !output_enable_n_in && calm |=> oe)
    else $error("output dropped");
  write_off_a: assert property (
    !global_write_n_in && adsp_n_in |=> !oe)
    else $error("driving during write");
  desel_off_a: assert property (off |=> !oe)
    else $error("driving while deselected");
  first_off_a: assert property (off ##1 sel |=> !oe)
    else $error("driving in first cycle");
  tdo_fall_a: assert property (
    $changed(tdo_out) |-> !$past(tck_in) && $past(tck_in, 2))
    else $error("test output moved off fall");
  data_hold_a: assert property (
    still [*2] |=> $stable(data_lanes_out))
    else $error("read data moved");
endmodule : sram_io_monitor
bind sync_sram_data_io_path sram_io_monitor u_mon (
  .clk_in(clk_in),
  .arst_n_in(arst_n_in),
  .adsp_n_in(adsp_n_in),
  .adsc_n_in(adsc_n_in),
  .adv_n_in(adv_n_in),
  .chip_select_primary_n_in(chip_select_primary_n_in),
  .global_write_n_in(global_write_n_in),
  .byte_write_enable_n_in(byte_write_enable_n_in),
  .output_enable_n_in(output_enable_n_in),
  .tck_in(tck_in),
  .data_lanes_out(data_lanes_out),
  .data_lanes_oe_out(data_lanes_oe_out),
  .parity_lanes_oe_out(parity_lanes_oe_out),
  .tdo_out(tdo_out)
);
`default_nettype wire

//--- testbench/bus_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module bus_host_model (
  input wire logic clk_in,
  input wire logic [35:0] dev_in,
  input wire logic dev_oe_in,
  input wire logic [35:0] host_in,
  input wire logic host_en_in,
  output logic [35:0] pin_out
);
  logic [35:0] last = 36'h0;
  always_ff @(posedge clk_in) last <= pin_out;
  // no pull on the lanes: a floating bus moves instead of holding old data
  assign pin_out = dev_oe_in ? dev_in : host_en_in ? host_in : ~last;
endmodule : bus_host_model
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic cs1_n = 1'b1, adsp_n = 1'b1, adsc_n = 1'b1, adv_n = 1'b1;
  logic gw_n = 1'b1, oe_n = 1'b1, bwe_n = 1'b1, mode = 1'b1;
  logic tck = 1'b0, tdi = 1'b0, h_en = 1'b0;
  logic ce2 = 1'b1, ce3_n = 1'b0;
  logic [3:0] bws_n = 4'hF;
  logic [5:0] addr = 6'h00;
  logic [35:0] h_d = 36'h0, mem [64], q [$];
  wire [35:0] pin;
  wire [31:0] dq_o;
  wire [3:0] p_o;
  wire oe, tdo;
  int seed = 43446, bad_count = 0, n_tests = 0, cycles = 0;
  initial forever #2.5 clk_in = ~clk_in;
  sync_sram_data_io_path uut (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .addr_in(addr), .adsp_n_in(adsp_n), .adsc_n_in(adsc_n),
    .adv_n_in(adv_n), .chip_select_primary_n_in(cs1_n),
    .chip_select_expand_high_in(ce2), .chip_select_expand_low_n_in(ce3_n),
    .global_write_n_in(gw_n), .byte_write_enable_n_in(bwe_n),
    .byte_write_select_n_in(bws_n), .output_enable_n_in(oe_n),
    .burst_order_in(mode), .data_lanes_in(pin[31:0]),
    .parity_lanes_in(pin[35:32]), .tck_in(tck), .tdi_in(tdi),
    .data_lanes_out(dq_o), .data_lanes_oe_out(oe), .parity_lanes_out(p_o),
    .parity_lanes_oe_out(), .tdo_out(tdo));
  bus_host_model host (.clk_in(clk_in), .dev_in({p_o, dq_o}),
    .dev_oe_in(oe), .host_in(h_d), .host_en_in(h_en), .pin_out(pin));
  task automatic chk(input string n, input logic [35:0] s, e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  function automatic logic [1:0] nx(input logic [1:0] s, n);
    return mode ? s ^ n : s + n;
  endfunction : nx
  task automatic cyc(input logic [5:0] c, input logic [35:0] e, logic pu);
    @(posedge clk_in);
    #1 {cs1_n, adsp_n, adsc_n, adv_n, gw_n, oe_n} = c;
    if (pu) q.push_back(e);
  endtask : cyc
  task automatic rst(input logic m);
    cyc(6'h3F, 36'h0, 1'b0);
    arst_n_in = 1'b0;
    mode = m;
    repeat (6) @(posedge clk_in);
    #1 arst_n_in = 1'b1;
  endtask : rst
  task automatic wr(input logic [5:0] a, input logic [3:0] bs);
    logic [5:0] w;
    logic [35:0] v;
    addr = a;
    for (int i = 0; i < 4; i++) begin
      w = {a[5:2], nx(a[1:0], 2'(i))};
      v = {4'($random(seed)), 32'($random(seed))};
      cyc({i == 0 ? 4'h5 : 4'h6, |bs, 1'b1}, 36'h0, 1'b0);
      h_d = v;
      h_en = 1'b1;
      bws_n = bs;
      bwe_n = ~|bs;
      for (int k = 0; k < 4; k++)
        if (!bs[k]) begin
          mem[w][8*k+:8] = v[8*k+:8];
          mem[w][32+k] = v[32+k];
        end
    end
    cyc(6'h3F, 36'h0, 1'b0);
    h_en = 1'b0;
    bwe_n = 1'b1;
    bws_n = 4'hF;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [3:0] om);
    cyc(6'h36, 36'h0, 1'b0);
    addr = a;
    cyc(6'h0E, 36'h0, 1'b0);
    for (int i = 1; i < 4; i++) begin
      cyc({5'h1D, om[i]}, mem[{a[5:2], nx(a[1:0], 2'(i))}], !om[i]);
      // expansion select moves mid-burst; it only counts on a strobe
      if (i < 3) ce2 = 1'($random(seed));
    end
    ce2 = 1'b1;
    cyc(6'h37, 36'h0, 1'b0);
  endtask : rd
  // reads are judged only while the device drives the wire
  always @(negedge clk_in)
    if (oe === 1'b1) begin
      if (q.size() == 0) chk("spare drive", 36'h1, 36'h0);
      else chk("read", pin, q.pop_front());
    end
  always @(posedge clk_in)
    if (++cycles == 1000) begin
      bad_count++;
      report_and_stop();
    end
  initial begin
    for (int m = 1; m >= 0; m--) begin
      rst(m[0]);
      wr(6'h00, 4'h0);
      wr(6'h05, 4'h0);
      wr(6'h05, 4'h5);
      rd(6'h03, 4'h0);
      rd(6'h06, 4'h4);
      // strobe with one expansion select off: no beat may be driven
      {ce2, ce3_n} = m[0] ? 2'b00 : 2'b11;
      cyc(6'h0E, 36'h0, 1'b0);
      repeat (3) cyc(6'h3A, 36'h0, 1'b0);
      {ce2, ce3_n} = 2'b10;
      cyc(6'h37, 36'h0, 1'b0);
      $display("burst test done, order %0d", m);
    end
    // quiet bus so the read data hold check gets exercised
    cyc(6'h3F, 36'h0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      tdi = 1'($random(seed));
      tck = 1'b1;
      repeat (6) @(posedge clk_in);
      #1 tck = 1'b0;
      repeat (6) @(posedge clk_in);
      #1 chk("tdo", 36'(tdo), 36'(tdi));
    end
    $display("test output test done");
    chk("pending", 36'(q.size()), 36'h0);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
